/* include/tfs_pkg.sv */
// ****************************************************************
// frame sync constants and types
// ****************************************************************
package tfs_pkg;

   // ****************************************************************
   // frame geometry
   // ****************************************************************
   localparam int unsigned FRAME_BITS   = 193;          // one overhead bit plus 24 x 8 bits
   localparam logic [7:0]  FRAME_LAST   = 8'hC0;        // last bit index of a frame (192)
   localparam logic [6:0]  MUX_LAST     = 7'h0B;        // last frame of a 12-frame multiframe
   localparam logic [6:0]  SLC_LAST     = 7'h47;        // last frame of a 72-frame multiframe
   localparam logic [6:0]  SLC_OVH_BASE = 7'h17;        // frame 24, first overhead frame

   // ****************************************************************
   // alignment patterns, newest F-bit in bit 0
   // ****************************************************************
   localparam logic [11:0] MUX_FAS      = 12'h8DC;      // 100011011100
   localparam logic [23:0] SLC_FAS      = 24'h23_7237;  // 001000110111001000110111
   localparam logic [7:0]  CH24_MASK    = 8'h9F;        // fixed positions of 0DY11101
   localparam logic [7:0]  CH24_VALUE   = 8'h1D;        // fixed values of 0DY11101
   localparam int unsigned CH24_D_POS   = 6;            // data-link bit
   localparam int unsigned CH24_Y_POS   = 5;            // alarm bit

   // ****************************************************************
   // search timing, counted in F-bits per candidate position
   // ****************************************************************
   localparam logic [6:0]  MUX_FILL     = 7'h0C;        // F-bits before a match can be trusted
   localparam logic [6:0]  SLC_FILL     = 7'h18;
   localparam logic [6:0]  MUX_DWELL    = 7'h17;        // 12 + 11 covers every phase
   localparam logic [6:0]  SLC_DWELL    = 7'h5F;        // 24 + 71 covers every phase
   localparam logic [6:0]  MUX_LOCK_FR  = 7'h0B;        // frame index at a match (frame 12)
   localparam logic [6:0]  SLC_LOCK_FR  = 7'h15;        // frame index at a match (frame 22)

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic {ST_SEARCH, ST_LOCKED} tfs_state_t;
   typedef enum logic [2:0] {
      OVH_CONC, OVH_SPOIL, OVH_MAINT, OVH_ALARM, OVH_SWITCH, OVH_ZERO
   } tfs_ovh_kind_t;

endpackage

/* tb/testbench.sv */
`timescale 1ns/100ps
module testbench
   import tfs_pkg::*;
;
   // ****************************************************************
   // signals
   // ****************************************************************
   logic          clk = 1'b0;
   logic          srst = 1'b1;
   logic          ce = 1'b1;        // never stalled, the model has no enable
   logic          run = 1'b0;
   logic          slc = 1'b0;
   logic          strict_sel = 1'b0;
   logic          gap = 1'b0;
   logic [6:0]    bad_c = 7'h00;
   logic [6:0]    bad_f = 7'h00;
   logic          bit_valid, bit_in, oof, mfs, fbit_error, ch24_error;
   logic          ch24_valid, ch24_dl, ch24_al, ovh_valid, ovh_bit;
   logic [6:0]    last_frame, frame_index;
   logic [7:0]    last_bit;
   logic [3:0]    ovh_index;
   tfs_ovh_kind_t ovh_kind;
   int            n_mismatch = 0;
   int            n_compared = 0;
   int            n_mfs, n_fe, n_ce, n_ovh, n_oof;   // events of one watch window

   always #5 clk = ~clk;

   tfs_frame_sync dut (.clk(clk), .srst(srst), .ce(ce), .bit_valid(bit_valid),
      .bit_in(bit_in), .slc_format_sel(slc), .strict_ch24_check_sel(strict_sel),
      .out_of_frame_status(oof), .multiframe_start_flag(mfs), .frame_index(frame_index),
      .fbit_error(fbit_error), .ch24_error(ch24_error), .ch24_valid(ch24_valid),
      .ch24_data_link(ch24_dl), .ch24_alarm(ch24_al), .ovh_valid(ovh_valid),
      .ovh_kind(ovh_kind), .ovh_index(ovh_index), .ovh_bit(ovh_bit));

   tfs_line_model line (.clk(clk), .srst(srst), .run(run), .slc(slc), .gap(gap),
      .bad_c(bad_c), .bad_f(bad_f), .bit_valid(bit_valid), .bit_in(bit_in),
      .last_frame(last_frame), .last_bit(last_bit));

   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic finish_test;
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // {bit, kind, index} of an overhead frame; all ones marks a frame with none
   function automatic logic [7:0] ovh_exp(input logic [6:0] fr);
      logic d;
      d = fr[2] ^ fr[3];
      if (fr[0] || fr < 7'h18) return 8'hff;
      if (fr <= 7'h2c) return {d, 3'h0, 4'(fr / 2 - 11)};
      if (fr <= 7'h32 || fr == 7'h46) return {fr == 7'h30 || fr == 7'h46, 3'h1, 4'h0};
      if (fr <= 7'h38) return {d, 3'h2, 4'(fr / 2 - 25)};
      if (fr <= 7'h3c) return {d, 3'h3, 4'(fr / 2 - 28)};
      if (fr <= 7'h44) return {d, 3'h4, 4'(fr / 2 - 30)};
      return {1'b0, 3'h5, 4'h0};
   endfunction

   // reset for six cycles, then the model starts two edges after release
   task automatic start(input logic fmt, input logic st, input logic g, input logic [6:0] bc);
      @(posedge clk);
      #1;
      srst = 1'b1;
      run = 1'b0;
      slc = fmt;
      strict_sel = st;
      gap = g;
      bad_c = bc;
      bad_f = 7'h00;
      repeat (6) @(posedge clk);
      #1;
      srst = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      run = 1'b1;
   endtask

   task automatic wait_lock(input int limit);
      int n;
      n = 0;
      while (oof !== 1'b0 && n < limit) begin
         @(posedge clk);
         #2;
         n++;
      end
      check("lock_reached", 16'(n < limit), 16'h0001);
   endtask

   // sample settled outputs each cycle, judge start, channel-24 and overhead pulses as they come, and count error pulses
   task automatic watch(input int cycles);
      int         per;
      int         since;
      logic [6:0] p;
      per = (slc ? 72 : 12) * 193 * (gap ? 2 : 1);
      since = -1;
      n_mfs = 0;
      n_fe = 0;
      n_ce = 0;
      n_ovh = 0;
      n_oof = 0;
      repeat (cycles) begin
         @(posedge clk);
         #2;
         since = (since < 0) ? since : since + 1;
         n_oof += int'(oof !== 1'b0);
         n_fe += int'(fbit_error === 1'b1);
         n_ce += int'(ch24_error === 1'b1);
         if (mfs === 1'b1) begin
            n_mfs++;
            check("mf_start_pos", {1'b0, last_frame, 8'(last_bit > 8'h01)}, 16'h0100);
            check("mf_start_index", {9'h000, frame_index}, 16'h0000);
            if (since >= 0) check("mf_length", 16'(since), 16'(per));
            since = 0;
         end
         if (ch24_valid === 1'b1 && oof === 1'b0 && !slc) begin
            p = (last_frame == 7'h01) ? 7'h0c : last_frame - 7'h01;
            check("ch24_side", {14'h0000, ch24_dl, ch24_al}, {14'h0000, p[0], p[1]});
         end
         if (ovh_valid === 1'b1 && oof === 1'b0) begin
            n_ovh++;
            check("ovh_fields", {8'h00, ovh_bit, ovh_kind, ovh_index}, {8'h00, ovh_exp(last_frame)});
         end
      end
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   // loose check at half rate; a broken byte in frame 7 must not stop lock
   task automatic sc_dm_loose_slow;
      start(1'b0, 1'b0, 1'b1, 7'h07);
      wait_lock(40 * 193 * 2);
      watch(2 * 12 * 193 * 2);
      check("dm_mf_count", 16'(n_mfs), 16'h0002);
      check("dm_ch24_errors", 16'(n_ce), 16'h0002);
      check("dm_f_errors", 16'(n_fe), 16'h0000);
   endtask

   // strict lock, then a wrong F-bit in frame 5 of every multiframe
   task automatic sc_dm_strict_ferr;
      start(1'b0, 1'b1, 1'b0, 7'h00);
      wait_lock(40 * 193);
      @(posedge clk);
      #1;
      bad_f = 7'h05;
      watch(3 * 12 * 193);
      check("dm_mf_count", 16'(n_mfs), 16'h0003);
      check("dm_f_errors", 16'(n_fe), 16'h0003);
      check("dm_ch24_errors", 16'(n_ce), 16'h0000);
      check("dm_stays_locked", 16'(n_oof), 16'h0000);
   endtask

   // strict check refuses a stream with one bad byte in twelve
   task automatic sc_dm_strict_reject;
      start(1'b0, 1'b1, 1'b0, 7'h07);
      watch(24 * 193);
      check("strict_no_lock", 16'(n_oof), 16'(24 * 193));
   endtask

   // loose check refuses a bad byte just before the first F-bit
   task automatic sc_dm_loose_reject;
      start(1'b0, 1'b0, 1'b0, 7'h0c);
      watch(24 * 193);
      check("loose_no_lock", 16'(n_oof), 16'(24 * 193));
   endtask

   task automatic sc_slc_lock;
      start(1'b1, 1'b0, 1'b0, 7'h00);
      wait_lock(200 * 193);
      watch(2 * 72 * 193);
      check("slc_mf_count", 16'(n_mfs), 16'h0002);
      check("slc_ovh_count", 16'(n_ovh), 16'h0032);
      check("slc_f_errors", 16'(n_fe), 16'h0000);
      check("slc_stays_locked", 16'(n_oof), 16'h0000);
   endtask

   initial begin
      sc_dm_loose_slow;
      sc_dm_strict_ferr;
      sc_dm_strict_reject;
      sc_dm_loose_reject;
      sc_slc_lock;
      finish_test;
   end

   // hang guard, well above the roughly 65k cycles the scenarios need
   initial begin
      #900_000;
      n_mismatch++;
      finish_test;
   end
endmodule

/* tb/tfs_line_model.sv */
`timescale 1ns/100ps
// ****************************************************************
// line decoder model: 193 bits a frame, F-bit first
// ****************************************************************
module tfs_line_model (
   // clock and control
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       run,
   input  wire logic       slc,      // 1 picks the 72-frame pattern
   input  wire logic       gap,      // 1 offers a bit every other cycle
   // faults, frame number or zero for none
   input  wire logic [6:0] bad_c,
   input  wire logic [6:0] bad_f,
   // line side
   output logic            bit_valid,
   output logic            bit_in,
   // position of the last bit taken
   output logic [6:0]      last_frame,
   output logic [7:0]      last_bit
);
   logic [6:0] fr_q = 7'h01;   // frame of the bit on offer
   logic [7:0] bt_q = 8'h00;   // bit within that frame
   logic       ph_q = 1'b0;    // valid phase in gap mode

   // F-bit of a frame; overhead data bits are made up from the frame number
   function automatic logic fexp(input logic [6:0] fr);
      logic [6:0] k;
      k = 7'((fr / 2 + 5) % 6);
      if (fr[0]) return ~fr[1];
      if (fr <= 7'h16) return (k >= 7'h02) && (k <= 7'h04);
      if (fr == 7'h2e || fr == 7'h32 || fr == 7'h48) return 1'b0;
      if (fr == 7'h30 || fr == 7'h46) return 1'b1;
      return fr[2] ^ fr[3];
   endfunction

   // one line bit: F-bit, payload, or channel 24 sent msb first
   function automatic logic gen(input logic [6:0] fr, input logic [7:0] bt);
      logic [7:0] ch;
      ch = {1'b0, fr[0], fr[1], 5'h1d};
      if (bt == 8'h00) return fexp(fr) ^ (fr == bad_f);
      if (bt >= 8'hb9) return ch[8'hc0 - bt] ^ ((fr == bad_c) && (bt == 8'hc0));
      return bt[0] ^ fr[0];
   endfunction

   initial begin
      bit_valid  = 1'b0;
      bit_in     = 1'b0;
      last_frame = 7'h00;
      last_bit   = 8'h00;
   end

   // changes land just after the edge; an idle line shows the inverse of its last bit
   always @(posedge clk) begin
      if (srst || !run) begin
         // open with frame 12 so channel 24 before frame 1 is seen, or
         // with frame 71 so the 24-bit sequence starts the stream
         fr_q = slc ? 7'h47 : 7'h0c;
         bt_q = 8'h00;
         ph_q = 1'b0;
         bit_valid <= #1 1'b0;
         bit_in    <= #1 ~bit_in;
      end else begin
         if (bit_valid) begin
            last_frame <= #1 fr_q;
            last_bit   <= #1 bt_q;
            bt_q = (bt_q == 8'hc0) ? 8'h00 : bt_q + 8'h01;
            if (bt_q == 8'h00) begin
               fr_q = (fr_q == (slc ? 7'h48 : 7'h0c)) ? 7'h01 : fr_q + 7'h01;
            end
         end
         ph_q = gap ? ~ph_q : 1'b1;
         bit_valid <= #1 ph_q;
         bit_in    <= #1 ph_q ? gen(fr_q, bt_q) : ~bit_in;
      end
   end
endmodule

/* verilog/tfs_fhist.sv */
`timescale 1ns/100ps
// ****************************************************************
// F-bit and channel-24 history at the candidate position
// ****************************************************************
module tfs_fhist
   import tfs_pkg::*;
#(
   parameter int unsigned F_DEPTH  = 24,   // longest alignment pattern
   parameter int unsigned C_DEPTH  = 12    // channel-24 checks kept
) (
   // clock and reset
   input  wire logic               clk,
   input  wire logic               srst,
   input  wire logic               ce,
   // history control
   input  wire logic               clr,
   input  wire logic               shift,
   input  wire logic               fbit,
   input  wire logic               ch24_ok,
   // history out, newest in bit 0
   output logic [F_DEPTH-1:0]      f_hist,
   output logic [C_DEPTH-1:0]      c_hist
);

   // the matcher compares against fixed 24 and 12 bit patterns
   if (F_DEPTH < 24 || C_DEPTH < 12) begin : g_depth_check
      $error("tfs_fhist: history too short for the alignment patterns");
   end

   typedef struct packed {
      logic [F_DEPTH-1:0] f;   // F-bits seen at the candidate
      logic [C_DEPTH-1:0] c;   // channel-24 fixed pattern results
   } tfs_hist_t;

   tfs_hist_t q, d;

   // clear wins over shift: a slipped candidate starts empty
   always_comb begin
      d = q;
      if (clr) begin
         d = '0;
      end else if (shift) begin
         d.f = {q.f[F_DEPTH-2:0], fbit};
         d.c = {q.c[C_DEPTH-2:0], ch24_ok};
      end
   end

   // state holds while the clock enable is low
   always_ff @(posedge clk) begin
      if (srst) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign f_hist = q.f;
   assign c_hist = q.c;

endmodule

/* verilog/tfs_frame_sync.sv */
`timescale 1ns/100ps
// Operation
// RQ1: multiplexer multiframe is twelve 193-bit frames
// RQ2: channel 24 carries 0DY11101 every frame
// RQ3: search F-bits for 100011011100
// RQ4: D is data link, Y alarm, six fixed
// RQ5: loose check: pattern good before first F-bit
// RQ6: strict check: pattern good before all twelve
// RQ7: multiplexer lock drives out-of-frame low
// RQ8: multiframe flag at first multiplexer bit
// RQ9: SLC-96 multiframe is 72 frames
// RQ10: lock on 24-bit SLC-96 F-bit sequence
// RQ11: frame 1 holds the first one
// RQ12: SLC-96 lock drives out-of-frame low
// RQ13: multiframe flag at first SLC-96 bit
// RQ14: map overhead F-bits from frame 24 onward
// RQ15: keep checking the stream after lock
// RQ16: slip candidate position until criteria met
module tfs_frame_sync
   import tfs_pkg::*;
(
   // clock, reset, enable
   input  wire logic          clk,
   input  wire logic          srst,
   input  wire logic          ce,
   // recovered line bits
   input  wire logic          bit_valid,
   input  wire logic          bit_in,
   // configuration
   input  wire logic          slc_format_sel,         // 1 SLC-96, 0 digital multiplexer
   input  wire logic          strict_ch24_check_sel,
   // alignment status
   output logic               out_of_frame_status,
   output logic               multiframe_start_flag,
   output logic [6:0]         frame_index,            // zero-based frame in multiframe
   // monitoring after lock
   output logic               fbit_error,
   output logic               ch24_error,
   // channel 24 side bits
   output logic               ch24_valid,
   output logic               ch24_data_link,
   output logic               ch24_alarm,
   // SLC-96 overhead bits
   output logic               ovh_valid,
   output tfs_ovh_kind_t      ovh_kind,
   output logic [3:0]         ovh_index,
   output logic               ovh_bit
);

   // ****************************************************************
   // decoding functions
   // ****************************************************************

   // channel-24 fixed positions, D and Y ignored
   function automatic logic ch24_good(input logic [7:0] b);
      ch24_good = ((b & CH24_MASK) == CH24_VALUE); // RQ2 RQ4
   endfunction

   // {checked, expected} for the F-bit of zero-based frame f
   function automatic logic [1:0] exp_fbit(input logic slc, input logic [6:0] f);
      logic [4:0] pos;
      // the sequence opens two frames before frame 1, so frame 2 is bit 20
      pos = 5'(5'd21 - f[4:0]);
      if (!slc) begin
         exp_fbit = {1'b1, MUX_FAS[4'(4'd11 - f[3:0])]};     // RQ3
      end else if (!f[0]) begin
         exp_fbit = {1'b1, ~f[1]};                          // odd frame terminal bits
      end else if (f < SLC_OVH_BASE) begin
         exp_fbit = {1'b1, SLC_FAS[pos]};                   // RQ10 RQ11
      end else if (f == SLC_LAST) begin
         exp_fbit = 2'b10;                                  // RQ14
      end else begin
         exp_fbit = 2'b00;
      end
   endfunction

   // overhead slot in frames 24..72 (odd zero-based index)
   function automatic logic [7:0] ovh_map(input logic [6:0] f);
      logic [4:0] s;
      s = 5'((f - SLC_OVH_BASE) >> 1);
      if (s <= 5'd10) begin
         ovh_map = {OVH_CONC, 5'(s + 5'd1)};
      end else if (s <= 5'd13 || s == 5'd23) begin
         ovh_map = {OVH_SPOIL, 5'd0};
      end else if (s <= 5'd16) begin
         ovh_map = {OVH_MAINT, 5'(s - 5'd13)};
      end else if (s <= 5'd18) begin
         ovh_map = {OVH_ALARM, 5'(s - 5'd16)};
      end else if (s <= 5'd22) begin
         ovh_map = {OVH_SWITCH, 5'(s - 5'd18)};
      end else begin
         ovh_map = {OVH_ZERO, 5'd0};
      end
   endfunction

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      tfs_state_t    st;        // searching or locked
      logic          slc;       // format the search was started for
      logic [7:0]    bcnt;      // bit index in frame, 0 is the F-bit
      logic [6:0]    frame;     // zero-based frame in multiframe
      logic [6:0]    dwell;     // F-bits tested at this candidate
      logic          slip;      // hold the bit count for one bit
      logic          chk;       // history just shifted, test it
      logic [7:0]    ch24;      // last eight bits, oldest at msb
      logic          mfs;       // multiframe start pulse
      logic          ferr;
      logic          cerr;
      logic          cval;
      logic          cd;
      logic          cy;
      logic          oval;
      tfs_ovh_kind_t okind;
      logic [3:0]    oidx;
      logic          obit;
   } tfs_state_rec_t;

   tfs_state_rec_t q, d;
   logic [23:0]    f_hist;      // candidate F-bits, newest in bit 0
   logic [11:0]    c_hist;      // channel-24 results, newest in bit 0
   logic           h_clr;
   logic           h_shift;
   logic           lock_hit;
   logic           fpos;

   // ****************************************************************
   // history of the candidate position
   // ****************************************************************
   tfs_fhist #(
      .F_DEPTH (24),
      .C_DEPTH (12)
   ) u_hist (
      .clk     (clk),
      .srst    (srst),
      .ce      (ce),
      .clr     (h_clr),
      .shift   (h_shift),
      .fbit    (bit_in),
      .ch24_ok (ch24_good(q.ch24)),
      .f_hist  (f_hist),
      .c_hist  (c_hist)
   );

   // alignment criteria for the format in use
   always_comb begin
      if (q.slc) begin
         lock_hit = (f_hist == SLC_FAS) && (q.dwell >= SLC_FILL);          // RQ10 RQ11
      end else begin
         lock_hit = (f_hist[11:0] == MUX_FAS) && (q.dwell >= MUX_FILL)     // RQ3
                  && (strict_ch24_check_sel ? (&c_hist) : c_hist[11]);    // RQ5 RQ6
      end
   end

   // the current bit sits in an F-bit position
   assign fpos = bit_valid && (q.bcnt == 8'h00) && !q.slip;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      logic [6:0] fr;
      logic [1:0] ex;
      logic [7:0] om;
      fr = 7'h00;
      ex = 2'b00;
      om = 8'h00;
      d = q;
      h_clr = 1'b0;
      h_shift = 1'b0;
      d.mfs = 1'b0;
      d.ferr = 1'b0;
      d.cerr = 1'b0;
      d.cval = 1'b0;
      d.oval = 1'b0;
      if (slc_format_sel != q.slc) begin
         // a format change restarts the search from scratch
         d.slc = slc_format_sel;
         d.st = ST_SEARCH;
         d.dwell = 7'h00;
         d.chk = 1'b0;
         h_clr = 1'b1;
      end else begin
         // lock one cycle after the matching F-bit entered the history
         if (q.chk) begin
            d.chk = 1'b0;
            if (q.st == ST_SEARCH && lock_hit) begin
               d.st = ST_LOCKED;                                          // RQ7 RQ12 RQ16
               d.frame = q.slc ? SLC_LOCK_FR : MUX_LOCK_FR;               // RQ11
            end
         end
         if (bit_valid) begin
            // bit counter; a slip stretches one frame by a bit
            if (q.slip) begin
               d.slip = 1'b0;                                             // RQ16
            end else begin
               d.bcnt = (q.bcnt == FRAME_LAST) ? 8'h00 : 8'(q.bcnt + 8'h01); // RQ1 RQ9
            end
            d.ch24 = {q.ch24[6:0], bit_in};
         end
         if (fpos) begin
            fr = (q.frame == (q.slc ? SLC_LAST : MUX_LAST)) ? 7'h00 : 7'(q.frame + 7'h01);
            d.frame = fr;                                                 // RQ1 RQ9
            if (q.st == ST_LOCKED) begin
               d.mfs = (fr == 7'h00);                                     // RQ8 RQ13
               ex = exp_fbit(q.slc, fr);
               d.ferr = ex[1] && (ex[0] != bit_in);                       // RQ15
               if (!q.slc) begin
                  // channel 24 ended on the bit just before this F-bit
                  d.cval = 1'b1;
                  d.cerr = !ch24_good(q.ch24);                            // RQ15
                  d.cd = q.ch24[CH24_D_POS];                              // RQ4
                  d.cy = q.ch24[CH24_Y_POS];                              // RQ4
               end else if (fr >= SLC_OVH_BASE && fr[0]) begin
                  om = ovh_map(fr);                                       // RQ14
                  d.oval = 1'b1;
                  d.okind = tfs_ovh_kind_t'(om[7:5]);
                  d.oidx = om[3:0];
                  d.obit = bit_in;
               end
            end else if (q.dwell == (q.slc ? SLC_DWELL : MUX_DWELL)) begin
               // candidate exhausted: move one bit later and start over
               d.slip = 1'b1;                                             // RQ16
               d.dwell = 7'h00;
               h_clr = 1'b1;
            end else begin
               h_shift = 1'b1;                                            // RQ16
               d.chk = 1'b1;
               d.dwell = 7'(q.dwell + 7'h01);
            end
         end
      end
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (srst) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign out_of_frame_status   = (q.st == ST_SEARCH);                    // RQ7 RQ12
   assign multiframe_start_flag = q.mfs;
   assign frame_index           = q.frame;
   assign fbit_error            = q.ferr;
   assign ch24_error            = q.cerr;
   assign ch24_valid            = q.cval;
   assign ch24_data_link        = q.cd;
   assign ch24_alarm            = q.cy;
   assign ovh_valid             = q.oval;
   assign ovh_kind              = q.okind;
   assign ovh_index             = q.oidx;
   assign ovh_bit               = q.obit;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence s_hit;
      ce && q.chk && q.st == ST_SEARCH && lock_hit && slc_format_sel == q.slc;
   endsequence

   sequence s_locked_fbit;
      ce && fpos && q.st == ST_LOCKED && slc_format_sel == q.slc;
   endsequence

   a_oof_clear_cause: assert property ($fell(out_of_frame_status) |-> $past(lock_hit)) // RQ7
      else $error("out-of-frame cleared without a pattern match");
   a_lock_drops_oof: assert property (s_hit |=> !out_of_frame_status) // RQ12
      else $error("match did not clear out-of-frame");
   a_mux_lock_pat: assert property (s_hit ##0 !q.slc |-> f_hist[11:0] == 12'h8DC) // RQ3
      else $error("multiplexer lock without alignment sequence");
   a_strict_ch24: assert property (s_hit ##0 !q.slc && strict_ch24_check_sel // RQ6
                                   |-> c_hist == 12'hFFF)
      else $error("strict lock without twelve good channel-24 patterns");
   a_loose_ch24: assert property (s_hit ##0 !q.slc |-> c_hist[11]) // RQ5
      else $error("lock without good channel-24 pattern before first F-bit");
   a_slc_lock_pat: assert property (s_hit ##0 q.slc |-> f_hist == 24'h23_7237) // RQ10
      else $error("SLC-96 lock without the 24-bit sequence");
   a_mux_frame_one: assert property (s_locked_fbit ##0 !q.slc && q.frame == MUX_LAST // RQ8
                                     |=> multiframe_start_flag)
      else $error("multiframe start missing after multiplexer frame 12");
   a_mfs_frame_zero: assert property (multiframe_start_flag |-> frame_index == 7'h00 // RQ13
                                      && !out_of_frame_status)
      else $error("multiframe start away from frame 1");
   a_slc_zero_slot: assert property (s_locked_fbit ##0 q.slc && q.frame == 7'h46 // RQ14
                                     |=> ovh_valid && ovh_kind == OVH_ZERO)
      else $error("frame 72 overhead not mapped as zero");
   a_ch24_monitor: assert property (s_locked_fbit ##0 !q.slc |=> ch24_valid // RQ15
                                    && ch24_error == !ch24_good($past(q.ch24)))
      else $error("channel 24 not checked after lock");

endmodule
